//--- src/serial_port_request_sync_arbiter_pkg.sv
package serial_port_request_sync_arbiter_pkg;
  // ==========================================
  // sizes
  localparam int N_PORT = 2;
  localparam int N_AB = 4;
  localparam int N_IRQ = 5;
  localparam int WORD_LEN = 8;
  localparam int CNT_W = 4;
  localparam int RX_W = 16;
  // ==========================================
  // channel numbering
  localparam int CH_A_TX = 0;
  localparam int CH_A_RX = 1;
  localparam int CH_B_TX = 2;
  localparam int CH_B_RX = 3;
  localparam int CH_EXT2 = 4;
  // ==========================================
  // link counts
  localparam logic [3:0] RX_LAST_BIT = 4'h7;
  localparam logic [3:0] RX_FIRST_NEXT = 4'h1;
  localparam logic [3:0] TX_REQ_BIT = 4'h2;
  // ==========================================
  // reset values
  localparam logic [15:0] RX_DATA_RST = 16'h0000;
  localparam logic [7:0] WORD_RST = 8'h00;
  // ==========================================
  // states
  typedef enum logic [2:0] {
    SVC_IDLE = 3'b001,
    SVC_XFER = 3'b010,
    SVC_FETCH = 3'b100
  } svc_e;
  typedef enum logic [2:0] {
    CP_IDLE = 3'b001,
    CP_WAIT = 3'b010,
    CP_TRY = 3'b100
  } cp_e;
  // ==========================================
  // service grant carrier
  typedef struct packed {
    logic [3:0] ab;
    logic [4:0] irq;
  } grant_s;
  localparam grant_s GRANT_RST = '{ab: 4'h0, irq: 5'h00};
  // ==========================================
  // processor stall causes
  typedef struct packed {
    logic wait_state;
    logic bus_req;
    logic multi_access;
  } stall_s;
endpackage : serial_port_request_sync_arbiter_pkg

//--- src/serial_port_request_sync_arbiter.sv
`timescale 1ns/1ps
// What this block does
// - receiver samples serial data on every falling serial clock edge
// - receive request raised on rising edge after a whole word arrived
// - two processor cycles synchronise the received word before processing
// - one cycle later expansion tried if companding on and circuit free
// - with companding, receive requests wait until expanded value is written
// - expansion writes only on instruction boundaries, one register at a time
// - port a wins the shared expansion circuit over port b
// - serial port requests are treated as asynchronous to the processor clock
// - synchronised request reaches processor two cycles after being raised
// - external request two sees the same synchronisation latency
// - pending requests are served only on instruction boundaries
// - service deferred by wait states, bus requests, multi access, mask, priority
// - order: a tx, a rx, b tx, b rx autobuffer, then unmasked interrupts
// - interrupt service spends one extra cycle fetching the first instruction
// - autobuffer service spends only its transfer cycle
// - with autobuffering, interrupt only when the index wraps the modulus
// - wraparound interrupt gets the same synchronisation delay
// - within a port, pending transmit autobuffer served before receive whatever the arrival
// - expansion holds the circuit one cycle; the loser waits one cycle
// - transmit request raised on falling edge while third bit shifts
module serial_port_request_sync_arbiter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire logic [1:0] sclk,
  input wire logic [1:0] serial_data_in,
  input wire logic [1:0] rx_frame,
  input wire logic [1:0] tx_shift,
  input wire logic external_request_two,
  input wire logic [1:0] compand_en,
  input wire logic [3:0] ab_en,
  input wire logic [4:0] irq_mask,
  input wire logic [3:0] ab_wrap,
  input wire logic instr_boundary,
  input wire serial_port_request_sync_arbiter_pkg::stall_s stall,
  output serial_port_request_sync_arbiter_pkg::grant_s grant_reg,
  output logic fetch_reg,
  output logic [1:0][15:0] rx_data_reg,
  output logic [1:0] rx_write_reg
);
  // ==========================================
  // link side, one generate slice per serial port
  logic [1:0][7:0] hold_reg;
  logic [1:0] rx_tgl_reg;
  logic [1:0] tx_tgl_reg;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_link
      logic [7:0] shift_reg;
      logic [3:0] rx_cnt_reg;
      logic [3:0] tx_cnt_reg;
      logic done_reg;
      // ==========================================
      // receive bit counter
      // an idle count holds at zero, so a free-running sclk finds no word
      wire cnt_idle = rx_cnt_reg == 4'h0;
      wire last_bit = !rx_frame[p] &&
                      (rx_cnt_reg == serial_port_request_sync_arbiter_pkg::RX_LAST_BIT);
      wire [3:0] rx_cnt_next = rx_frame[p] ? serial_port_request_sync_arbiter_pkg::RX_FIRST_NEXT :
                               (last_bit || cnt_idle) ? 4'h0 : rx_cnt_reg + 4'h1;
      wire [7:0] word_next = {shift_reg[6:0], serial_data_in[p]};

      // ==========================================
      // receive shifter
      always_ff @(negedge sclk[p] or posedge sys_rst) begin
        if (sys_rst) begin
          shift_reg <= serial_port_request_sync_arbiter_pkg::WORD_RST;
          rx_cnt_reg <= 4'h0;
          done_reg <= 1'b0;
          hold_reg[p] <= serial_port_request_sync_arbiter_pkg::WORD_RST;
        end else begin
          shift_reg <= word_next;
          rx_cnt_reg <= rx_cnt_next;
          done_reg <= last_bit;
          if (last_bit) begin
            hold_reg[p] <= word_next;
          end
        end
      end

      // ==========================================
      // transmit bit counter
      // the count restarts every word, so back-to-back words each raise one request
      // sys_ce cannot stop sclk, so link state runs on while the core is frozen
      wire tx_word_end = tx_cnt_reg == 4'(serial_port_request_sync_arbiter_pkg::WORD_LEN);
      wire [3:0] tx_cnt_next = !tx_shift[p] ? 4'h0 :
                               tx_word_end ? 4'h1 : tx_cnt_reg + 4'h1;
      wire tx_hit = tx_shift[p] &&
                    (tx_cnt_reg == serial_port_request_sync_arbiter_pkg::TX_REQ_BIT);

      // the hold word stays still for a whole word time, long enough to cross
      always_ff @(posedge sclk[p] or posedge sys_rst) begin
        if (sys_rst) begin
          rx_tgl_reg[p] <= 1'b0;
          tx_cnt_reg <= 4'h0;
        end else begin
          if (done_reg) begin
            rx_tgl_reg[p] <= !rx_tgl_reg[p];
          end
          tx_cnt_reg <= tx_cnt_next;
        end
      end

      // ==========================================
      // transmit request
      always_ff @(negedge sclk[p] or posedge sys_rst) begin
        if (sys_rst) begin
          tx_tgl_reg[p] <= 1'b0;
        end else if (tx_hit) begin
          tx_tgl_reg[p] <= !tx_tgl_reg[p];
        end
      end
    end
  endgenerate

  // ==========================================
  // crossing into the processor clock
  // toggles carry events, so a slow sclk never loses or doubles one
  // a toggle that misses setup at the first stage is seen one cycle later
  wire [4:0] async_in = {external_request_two, rx_tgl_reg[1], tx_tgl_reg[1],
                         rx_tgl_reg[0], tx_tgl_reg[0]};
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] last_reg;
  // ==========================================
  // event detection after the second stage
  // the pin is a level and only its rise counts; port requests arrive as toggles
  wire ext_rise = sync_reg[4] & !last_reg[4];
  wire [3:0] port_ev = sync_reg[3:0] ^ last_reg[3:0];
  wire [4:0] sync_ev = {ext_rise, port_ev};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
      last_reg <= 5'h00;
    end else if (sys_ce) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // ==========================================
  // wrap event delay
  // wrap events are delayed by as many stages as a crossed request
  logic [3:0] wrap_d1_reg;
  logic [3:0] wrap_d2_reg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrap_d1_reg <= 4'h0;
      wrap_d2_reg <= 4'h0;
    end else if (sys_ce) begin
      wrap_d1_reg <= ab_wrap;
      wrap_d2_reg <= wrap_d1_reg;
    end
  end

  // ==========================================
  // receive expansion, shared circuit
  serial_port_request_sync_arbiter_pkg::cp_e [1:0] cp_reg;
  logic [1:0][7:0] cap_reg;
  wire [1:0] rx_ev = {sync_ev[serial_port_request_sync_arbiter_pkg::CH_B_RX],
                      sync_ev[serial_port_request_sync_arbiter_pkg::CH_A_RX]};
  wire [1:0] cp_try = {cp_reg[1] == serial_port_request_sync_arbiter_pkg::CP_TRY,
                       cp_reg[0] == serial_port_request_sync_arbiter_pkg::CP_TRY};
  // one grant per cycle, taken only on a boundary
  wire [1:0] exp_go = {cp_try[1] & instr_boundary & !cp_try[0],
                       cp_try[0] & instr_boundary};
  wire [1:0] plain_ev = rx_ev & ~compand_en;
  wire [1:0] rx_ready = plain_ev | exp_go;

  generate
    for (p = 0; p < 2; p++) begin : g_exp
      // ==========================================
      // per port expansion state
      // a word landing mid-expansion replaces the captured one
      // law tables sit elsewhere; here the word is sign-extended as expanded
      wire [15:0] expanded = {{8{cap_reg[p][7]}}, cap_reg[p]};
      wire [15:0] plain = {8'h00, hold_reg[p]};
      serial_port_request_sync_arbiter_pkg::cp_e cp_next;
      always_comb begin
        cp_next = cp_reg[p];
        case (cp_reg[p])
          serial_port_request_sync_arbiter_pkg::CP_IDLE: begin
            if (rx_ev[p] && compand_en[p]) begin
              cp_next = serial_port_request_sync_arbiter_pkg::CP_WAIT;
            end
          end
          serial_port_request_sync_arbiter_pkg::CP_WAIT: begin
            cp_next = serial_port_request_sync_arbiter_pkg::CP_TRY;
          end
          serial_port_request_sync_arbiter_pkg::CP_TRY: begin
            if (exp_go[p]) begin
              cp_next = serial_port_request_sync_arbiter_pkg::CP_IDLE;
            end
          end
          default: cp_next = serial_port_request_sync_arbiter_pkg::CP_IDLE;
        endcase
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cp_reg[p] <= serial_port_request_sync_arbiter_pkg::CP_IDLE;
          cap_reg[p] <= serial_port_request_sync_arbiter_pkg::WORD_RST;
          rx_data_reg[p] <= serial_port_request_sync_arbiter_pkg::RX_DATA_RST;
          rx_write_reg[p] <= 1'b0;
        end else if (sys_ce) begin
          cp_reg[p] <= cp_next;
          rx_write_reg[p] <= rx_ready[p];
          if (rx_ev[p]) begin
            cap_reg[p] <= hold_reg[p];
          end
          if (exp_go[p]) begin
            rx_data_reg[p] <= expanded;
          end else if (plain_ev[p]) begin
            rx_data_reg[p] <= plain;
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // pending requests
  wire [3:0] chan_ev = {rx_ready[1], sync_ev[serial_port_request_sync_arbiter_pkg::CH_B_TX],
                        rx_ready[0], sync_ev[serial_port_request_sync_arbiter_pkg::CH_A_TX]};
  wire [3:0] ab_set = chan_ev & ab_en;
  wire [4:0] irq_set = {sync_ev[serial_port_request_sync_arbiter_pkg::CH_EXT2],
                        (chan_ev & ~ab_en) | (wrap_d2_reg & ab_en)};
  logic [3:0] ab_pend_reg;
  logic [4:0] irq_pend_reg;
  serial_port_request_sync_arbiter_pkg::svc_e svc_reg;
  serial_port_request_sync_arbiter_pkg::svc_e svc_next;

  // ==========================================
  // service selection
  wire idle = svc_reg == serial_port_request_sync_arbiter_pkg::SVC_IDLE;
  wire stalled = stall.wait_state | stall.bus_req | stall.multi_access;
  wire can_serve = idle & instr_boundary & !stalled;
  wire [4:0] irq_live = irq_pend_reg & irq_mask;
  // lowest set bit is the highest priority; tx sits below rx in each port
  wire [3:0] ab_pick = ab_pend_reg & (~ab_pend_reg + 4'h1);
  wire [4:0] irq_pick = irq_live & (~irq_live + 5'h01);
  wire any_ab = |ab_pend_reg;
  wire [3:0] ab_clr = can_serve ? ab_pick : 4'h0;
  wire [4:0] irq_clr = (can_serve && !any_ab) ? irq_pick : 5'h00;

  // ==========================================
  // service sequencer
  always_comb begin
    svc_next = svc_reg;
    case (svc_reg)
      serial_port_request_sync_arbiter_pkg::SVC_IDLE: begin
        if (|ab_clr || |irq_clr) begin
          svc_next = serial_port_request_sync_arbiter_pkg::SVC_XFER;
        end
      end
      serial_port_request_sync_arbiter_pkg::SVC_XFER: begin
        // an autobuffer transfer ends here; an interrupt goes on to fetch
        if (fetch_reg) begin
          svc_next = serial_port_request_sync_arbiter_pkg::SVC_FETCH;
        end else begin
          svc_next = serial_port_request_sync_arbiter_pkg::SVC_IDLE;
        end
      end
      serial_port_request_sync_arbiter_pkg::SVC_FETCH: begin
        svc_next = serial_port_request_sync_arbiter_pkg::SVC_IDLE;
      end
      default: svc_next = serial_port_request_sync_arbiter_pkg::SVC_IDLE;
    endcase
  end

  // ==========================================
  // next values of the service registers
  // a new request in the clearing cycle survives, so none is lost
  wire [3:0] ab_pend_next = (ab_pend_reg & ~ab_clr) | ab_set;
  wire [4:0] irq_pend_next = (irq_pend_reg & ~irq_clr) | irq_set;
  wire in_fetch = svc_reg == serial_port_request_sync_arbiter_pkg::SVC_FETCH;
  // fetch stands through the transfer and the fetch cycle of an interrupt
  wire fetch_next = idle ? |irq_clr : (in_fetch ? 1'b0 : fetch_reg);
  serial_port_request_sync_arbiter_pkg::grant_s grant_next;
  assign grant_next = '{ab: ab_clr, irq: irq_clr};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_pend_reg <= 4'h0;
      irq_pend_reg <= 5'h00;
      svc_reg <= serial_port_request_sync_arbiter_pkg::SVC_IDLE;
      grant_reg <= serial_port_request_sync_arbiter_pkg::GRANT_RST;
      fetch_reg <= 1'b0;
    end else if (sys_ce) begin
      ab_pend_reg <= ab_pend_next;
      irq_pend_reg <= irq_pend_next;
      svc_reg <= svc_next;
      grant_reg <= grant_next;
      fetch_reg <= fetch_next;
    end
  end
endmodule : serial_port_request_sync_arbiter

//--- test/serial_link_model.sv
`timescale 1ns/1ps
// ==========================================
// far end of one link: clock, data, framing
module serial_link_model (
  output logic sclk,
  output logic sdata,
  output logic frame,
  output logic tx_busy
);
  // clock stands still high outside frames
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
    frame = 1'b0;
    tx_busy = 1'b0;
  end
  task automatic pulse();
    #3 sclk = 1'b0;
    #3 sclk = 1'b1;
  endtask : pulse
  // msb first, stable across each falling edge
  task automatic send(input logic [7:0] w, input logic tx);
    tx_busy = tx;
    for (int i = 7; i >= 0; i--) begin
      sdata = w[i];
      frame = (i == 7);
      pulse();
    end
    #3 frame = 1'b0;
    tx_busy = 1'b0;
    // released line must not look like the last bit
    sdata = ~w[0];
  endtask : send
endmodule : serial_link_model

//--- test/request_arbiter_asserts.sv
`timescale 1ns/1ps
module request_arbiter_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire logic [1:0] compand_en,
  input wire logic [4:0] irq_mask,
  input wire logic instr_boundary,
  input wire serial_port_request_sync_arbiter_pkg::stall_s stall,
  input wire serial_port_request_sync_arbiter_pkg::grant_s grant_reg,
  input wire logic fetch_reg,
  input wire logic [1:0][15:0] rx_data_reg,
  input wire logic [1:0] rx_write_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // service
  a_grant_one_hot: assert property ($onehot0(grant_reg))
    else $error("grant not one-hot");
  a_grant_at_boundary: assert property (grant_reg != 9'h0 |->
    $past(instr_boundary) && $past(stall) == 3'h0 && $past(sys_ce))
    else $error("grant off boundary or stalled");
  a_ab_no_fetch: assert property (|grant_reg.ab |-> !fetch_reg ##1 grant_reg == 9'h0)
    else $error("autobuffer service too long");
  a_irq_fetch_seq: assert property (|grant_reg.irq |-> fetch_reg
    ##1 (fetch_reg && grant_reg == 9'h0) ##1 (!fetch_reg && grant_reg == 9'h0))
    else $error("interrupt fetch cycle wrong");
  a_fetch_has_cause: assert property ($rose(fetch_reg) |-> |grant_reg.irq)
    else $error("fetch without interrupt");
  a_irq_unmasked: assert property (|grant_reg.irq |->
    (grant_reg.irq & ~$past(irq_mask)) == 5'h00) else $error("masked interrupt served");
  // ==========================================
  // receive writes
  a_one_expand: assert property (compand_en == 2'b11 |-> $onehot0(rx_write_reg))
    else $error("two expansions at once");
  a_expand_boundary: assert property (rx_write_reg[0] && $past(compand_en[0])
    |-> $past(instr_boundary)) else $error("expansion off boundary");
  a_data_with_write: assert property ($changed(rx_data_reg[0]) |-> rx_write_reg[0])
    else $error("receive data changed silently");
endmodule : request_arbiter_asserts

//--- test/tb_serial_port_request_sync_arbiter.sv
`timescale 1ns/1ps
module tb_serial_port_request_sync_arbiter;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sys_ce = 1'b1;
  logic external_request_two = 1'b0;
  logic [1:0] compand_en = 2'b00;
  logic [3:0] ab_en = 4'h0;
  logic [4:0] irq_mask = 5'h00;
  logic [3:0] ab_wrap = 4'h0;
  logic instr_boundary = 1'b1;
  serial_port_request_sync_arbiter_pkg::stall_s stall = 3'h0;
  serial_port_request_sync_arbiter_pkg::grant_s grant_reg;
  logic fetch_reg;
  logic [1:0][15:0] rx_data_reg;
  logic [1:0] rx_write_reg;
  wire [1:0] sclk, sdi, frm, txs;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  always #4 sys_clk = ~sys_clk;
  serial_link_model la (.sclk(sclk[0]), .sdata(sdi[0]), .frame(frm[0]), .tx_busy(txs[0]));
  serial_link_model lb (.sclk(sclk[1]), .sdata(sdi[1]), .frame(frm[1]), .tx_busy(txs[1]));
  serial_port_request_sync_arbiter dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sys_ce(sys_ce), .sclk(sclk), .serial_data_in(sdi), .rx_frame(frm), .tx_shift(txs),
    .external_request_two(external_request_two), .compand_en(compand_en), .ab_en(ab_en),
    .irq_mask(irq_mask), .ab_wrap(ab_wrap), .instr_boundary(instr_boundary),
    .stall(stall), .grant_reg(grant_reg), .fetch_reg(fetch_reg),
    .rx_data_reg(rx_data_reg), .rx_write_reg(rx_write_reg));
  // ==========================================
  // helpers
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_grant(input logic [8:0] exp);
    int k;
    k = 0;
    do begin
      step(1);
      k++;
    end while (grant_reg === 9'h0 && k < 60);
    cmp({7'h00, grant_reg}, {7'h00, exp});
  endtask : wait_grant
  task automatic wait_write(input logic [1:0] m);
    n = 0;
    while ((rx_write_reg & m) === 2'b00 && n < 30) begin
      step(1);
      n++;
    end
  endtask : wait_write
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // scenarios
  task automatic t_plain();
    irq_mask = 5'h02;
    la.send(8'ha5, 1'b0);
    wait_write(2'b01);
    cmp({15'h0, n >= 3 && n <= 5}, 16'h1);
    cmp(rx_data_reg[0], 16'h00a5);
    wait_grant(9'h002);
    cmp({15'h0, fetch_reg}, 16'h1);
    step(1);
    cmp({15'h0, fetch_reg}, 16'h1);
    step(1);
    cmp({15'h0, fetch_reg}, 16'h0);
  endtask : t_plain
  task automatic t_compand();
    compand_en = 2'b11;
    instr_boundary = 1'b0;
    irq_mask = 5'h00;
    fork
      la.send(8'h85, 1'b0);
      lb.send(8'h7c, 1'b0);
    join
    step(12);
    cmp({14'h0, rx_write_reg}, 16'h0);
    instr_boundary = 1'b1;
    wait_write(2'b11);
    cmp({14'h0, rx_write_reg}, 16'h1);
    cmp(rx_data_reg[0], 16'hff85);
    wait_write(2'b10);
    cmp(n[15:0], 16'h1);
    cmp(rx_data_reg[1], 16'h007c);
    irq_mask = 5'h0a;
    wait_grant(9'h002);
    wait_grant(9'h008);
    compand_en = 2'b00;
  endtask : t_compand
  task automatic t_prio();
    ab_en = 4'hf;
    irq_mask = 5'h00;
    stall = 3'b010;
    fork
      la.send(8'h3c, 1'b1);
      lb.send(8'hc3, 1'b1);
    join
    step(12);
    cmp({7'h00, grant_reg}, 16'h0);
    stall = 3'b100;
    step(1);
    cmp({7'h00, grant_reg}, 16'h0);
    stall = 3'b001;
    step(1);
    cmp({7'h00, grant_reg}, 16'h0);
    stall = 3'h0;
    for (int i = 0; i < 4; i++) begin
      wait_grant(9'h020 << i);
      cmp({15'h0, fetch_reg}, 16'h0);
    end
  endtask : t_prio
  task automatic t_wrap();
    ab_wrap = 4'h2;
    step(1);
    ab_wrap = 4'h0;
    step(8);
    cmp({7'h00, grant_reg}, 16'h0);
    sys_ce = 1'b0;
    irq_mask = 5'h02;
    step(4);
    cmp({7'h00, grant_reg}, 16'h0);
    sys_ce = 1'b1;
    wait_grant(9'h002);
    irq_mask = 5'h10;
    external_request_two = 1'b1;
    wait_grant(9'h010);
    external_request_two = 1'b0;
  endtask : t_wrap
  initial begin
    fork
      step(5);
      la.pulse();
      lb.pulse();
    join
    sys_rst = 1'b0;
    step(2);
    t_plain();
    t_compand();
    t_prio();
    t_wrap();
    tally_and_finish();
  end
  // hang guard, far beyond the eighty or so cycles the scenarios need
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_serial_port_request_sync_arbiter
bind serial_port_request_sync_arbiter request_arbiter_asserts chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .sys_ce(sys_ce), .compand_en(compand_en), .irq_mask(irq_mask),
  .instr_boundary(instr_boundary), .stall(stall), .grant_reg(grant_reg),
  .fetch_reg(fetch_reg), .rx_data_reg(rx_data_reg), .rx_write_reg(rx_write_reg));
